/* File: logic/txw_pkg.sv */
// ****************************************
// Shared constants for the host write port
// ****************************************
package txw_pkg;

	// Host bus geometry
	localparam int TXW_DATA_W    = 32;
	localparam int TXW_HALF_W    = 16;
	localparam int TXW_ADDR_MSB  = 7;
	localparam int TXW_SYNC_W    = 2;

	// Transmit FIFO depth in words
	localparam int TXW_FIFO_DEPTH = 16;

	// Ordinary-mode alias of the transmit data port, address bits [7:5]
	localparam logic [2:0] TXW_TX_ALIAS = 3'h1;

	// Lane select bit used to pair halves on a 16-bit bus
	localparam int TXW_LANE_BIT = 1;

	// Host strobe timing, kept for reference; the bench does not use it
	localparam int TXW_CLK_PERIOD_NS = 10;
	localparam int TXW_T_CYCLE_NS    = 45;
	localparam int TXW_T_ASSERT_NS   = 32;
	localparam int TXW_T_RELEASE_NS  = 13;
	localparam int TXW_CYCLE_CLKS    =
		(TXW_T_CYCLE_NS + TXW_CLK_PERIOD_NS - 1) / TXW_CLK_PERIOD_NS;
	localparam int TXW_ASSERT_CLKS   =
		(TXW_T_ASSERT_NS + TXW_CLK_PERIOD_NS - 1) / TXW_CLK_PERIOD_NS;
	localparam int TXW_RELEASE_CLKS  =
		(TXW_T_RELEASE_NS + TXW_CLK_PERIOD_NS - 1) / TXW_CLK_PERIOD_NS;

	// Reset values
	localparam logic [TXW_DATA_W-1:0] TXW_DATA_RST = 32'h0000_0000;
	localparam logic [TXW_HALF_W-1:0] TXW_HALF_RST = 16'h0000;

endpackage

/* File: logic/txw_stream_if.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Word stream between port and FIFO
// ****************************************
interface txw_stream_if #(
	parameter int WIDTH = 32
);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: logic/txw_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Transmit data FIFO with registered output
// ****************************************
module txw_fifo import txw_pkg::*; #(
	parameter int WIDTH = TXW_DATA_W,
	parameter int DEPTH = TXW_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	// Fill side
	txw_stream_if.snk        in_s,
	// Drain side
	output logic [WIDTH-1:0] out_data,
	output logic             out_valid,
	input  wire logic        out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	wire              full;
	wire              empty;
	wire              do_write;
	wire              do_load;

	// Occupancy and handshakes
	assign full      = (count_reg == (AW+1)'(DEPTH));
	assign empty     = (count_reg == '0);
	assign in_s.ready = ~full;
	assign do_write  = in_s.valid & ~full;
	assign do_load   = ~empty & (~out_valid | out_ready);

	// Count follows writes and loads
	always_comb begin
		count_next = count_reg;
		if (do_write & ~do_load) begin
			count_next = count_reg + (AW+1)'(1);
		end else if (~do_write & do_load) begin
			count_next = count_reg - (AW+1)'(1);
		end
	end

	// Storage array, no reset needed
	always_ff @(posedge clock) begin
		if (do_write) begin
			mem_reg[wr_ptr_reg] <= in_s.data;
		end
	end

	// Pointers, count and output stage
	always_ff @(posedge clock) begin
		if (reset) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			out_valid  <= 1'b0;
			out_data   <= '0;
		end else begin
			count_reg <= count_next;
			if (do_write) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
					: wr_ptr_reg + AW'(1);
			end
			if (do_load) begin
				out_data   <= mem_reg[rd_ptr_reg];
				out_valid  <= 1'b1;
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
					: rd_ptr_reg + AW'(1);
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* File: logic/txw_write_port.sv */
// Behaviour
// R1 - In direct mode upper address bits are ignored; writes go to the FIFO.
// R2 - Direct mode applies only to a write with FIFO select held high.
// R3 - The host holds FIFO select like an address bit, sampled alike.
// R4 - Direct writes work on 32-bit and 16-bit buses with one protocol.
// R5 - On the 16-bit bus only the low sixteen data lines are captured.
// R6 - The two word-select address lines are still decoded in direct mode; the code decodes only address bit 1 (TXW_LANE_BIT).
// R7 - Address bits above the word-select lines are ignored in direct mode.
// R8 - A cycle starts with both strobes low and ends when either rises.
// R9 - The host keeps both strobes low 32 ns and starts cycles 45 ns apart.
// R10 - The host keeps the strobe pair released at least 13 ns per gap.
// R11 - The host may frame cycles with either strobe, released between.
// R12 - Each completed direct write pushes one word into the FIFO in order; on the 16-bit bus the code pushes one word per lower/upper lane pair.
`timescale 1ns/10ps
`default_nettype none
module txw_write_port import txw_pkg::*; #(
	parameter int FIFO_DEPTH = TXW_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  reset,
	// Host bus pins
	input  wire logic                  chip_select_n,
	input  wire logic                  write_strobe_n,
	input  wire logic                  fifo_sel,
	input  wire logic [TXW_ADDR_MSB:1] addr,
	input  wire logic [TXW_DATA_W-1:0] data,
	input  wire logic                  bus_16bit,
	// Transmit word stream
	output logic      [TXW_DATA_W-1:0] tx_data,
	output logic                       tx_valid,
	input  wire logic                  tx_ready,
	// Ordinary register writes
	output logic                       reg_wr_pulse,
	output logic      [TXW_ADDR_MSB:1] reg_wr_addr,
	output logic      [TXW_DATA_W-1:0] reg_wr_data,
	// Status
	output logic                       overflow,
	input  wire logic                  overflow_clear
);
	// ****************************************
	// Pin synchroniser
	// ****************************************
	// Bit positions inside the synchronised pin word
	localparam int POS_NARROW = 0;
	localparam int POS_DATA   = POS_NARROW + 1;
	localparam int POS_ADDR   = POS_DATA + TXW_DATA_W;
	localparam int POS_SEL    = POS_ADDR + TXW_ADDR_MSB;
	localparam int POS_WR     = POS_SEL + 1;
	localparam int POS_CS     = POS_WR + 1;
	localparam int PIN_W      = POS_CS + 1;

	logic [PIN_W-1:0] pin_meta_reg;
	logic [PIN_W-1:0] pin_sync_reg;
	wire  [PIN_W-1:0] pin_raw;

	assign pin_raw = {chip_select_n, write_strobe_n, fifo_sel,
		addr, data, bus_16bit};

	// Two flops on every host pin
	always_ff @(posedge clock) begin
		if (reset) begin
			pin_meta_reg <= {2'b11, {(PIN_W-2){1'b0}}};
			pin_sync_reg <= {2'b11, {(PIN_W-2){1'b0}}};
		end else begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// Field split of the synchronised pins
	wire                  cs_n_s   = pin_sync_reg[POS_CS];
	wire                  wr_n_s   = pin_sync_reg[POS_WR];
	wire                  sel_s    = pin_sync_reg[POS_SEL];
	wire [TXW_ADDR_MSB:1] addr_s   =
		pin_sync_reg[POS_SEL-1:POS_ADDR];
	wire [TXW_DATA_W-1:0] data_s   = pin_sync_reg[POS_ADDR-1:POS_DATA];
	wire                  narrow_s = pin_sync_reg[POS_NARROW];

	// ****************************************
	// Cycle framing
	// ****************************************
	logic                  active_reg;
	logic                  cap_sel_reg;
	logic                  cap_narrow_reg;
	logic [TXW_ADDR_MSB:1] cap_addr_reg;
	logic [TXW_DATA_W-1:0] cap_data_reg;

	// R8 both low starts
	wire strobe_on = ~cs_n_s & ~wr_n_s;
	// R8 either high ends
	wire cycle_end = active_reg & ~strobe_on;

	// Track the cycle and keep the last sample taken inside it
	always_ff @(posedge clock) begin
		if (reset) begin
			active_reg     <= 1'b0;
			cap_sel_reg    <= 1'b0;
			cap_narrow_reg <= 1'b0;
			cap_addr_reg   <= '0;
			cap_data_reg   <= TXW_DATA_RST;
		end else begin
			active_reg <= strobe_on;
			// R3 select sampled with address
			if (strobe_on) begin
				cap_sel_reg    <= sel_s;
				cap_narrow_reg <= narrow_s;
				cap_addr_reg   <= addr_s;
				cap_data_reg   <= data_s;
			end
		end
	end

	// ****************************************
	// Address decode and word assembly
	// ****************************************
	logic [TXW_HALF_W-1:0] half_reg;

	// Lowest bit of the ordinary-mode alias field
	localparam int ALIAS_LSB = TXW_ADDR_MSB - 2;

	// R2 select high means direct
	wire direct_hit = cap_sel_reg;
	wire alias_hit  = (cap_addr_reg[TXW_ADDR_MSB:ALIAS_LSB] == TXW_TX_ALIAS);
	// R1 R7 upper bits not decoded
	wire to_fifo    = direct_hit | alias_hit;
	// R6 lane line still decoded
	wire upper_lane = cap_addr_reg[TXW_LANE_BIT];
	// R5 only low half on narrow bus
	wire [TXW_HALF_W-1:0] low_half = cap_data_reg[TXW_HALF_W-1:0];
	// R4 both widths, same framing
	wire fifo_end   = cycle_end & to_fifo;
	wire half_store = fifo_end & cap_narrow_reg & ~upper_lane;
	wire push_req   = fifo_end & (~cap_narrow_reg | upper_lane);
	wire [TXW_DATA_W-1:0] push_word = cap_narrow_reg
		? {low_half, half_reg} : cap_data_reg;

	// Lower half waits for its partner
	always_ff @(posedge clock) begin
		if (reset) begin
			half_reg <= TXW_HALF_RST;
		end else if (half_store) begin
			half_reg <= low_half;
		end
	end

	// ****************************************
	// Ordinary register write strobe
	// ****************************************
	wire reg_end = cycle_end & ~to_fifo;
	// Narrow bus clears the upper half
	wire [TXW_DATA_W-1:0] reg_word = cap_narrow_reg
		? {{TXW_HALF_W{1'b0}}, low_half} : cap_data_reg;

	// One pulse per addressed write
	always_ff @(posedge clock) begin
		if (reset) begin
			reg_wr_pulse <= 1'b0;
			reg_wr_addr  <= '0;
			reg_wr_data  <= TXW_DATA_RST;
		end else begin
			reg_wr_pulse <= reg_end;
			if (reg_end) begin
				reg_wr_addr <= cap_addr_reg;
				reg_wr_data <= reg_word;
			end
		end
	end

	// ****************************************
	// Push stage into the FIFO
	// ****************************************
	txw_stream_if #(.WIDTH(TXW_DATA_W)) push_if ();

	logic                  pend_valid_reg;
	logic [TXW_DATA_W-1:0] pend_data_reg;

	assign push_if.valid = pend_valid_reg;
	assign push_if.data  = pend_data_reg;

	wire pend_busy = pend_valid_reg & ~push_if.ready;
	wire drop      = push_req & pend_busy;

	// R12 one word per 32-bit cycle or 16-bit lane pair, in order
	always_ff @(posedge clock) begin
		if (reset) begin
			pend_valid_reg <= 1'b0;
			pend_data_reg  <= TXW_DATA_RST;
		end else if (push_req & ~pend_busy) begin
			pend_valid_reg <= 1'b1;
			pend_data_reg  <= push_word;
		end else if (push_if.ready) begin
			pend_valid_reg <= 1'b0;
		end
	end

	// Sticky loss flag, set wins over clear
	always_ff @(posedge clock) begin
		if (reset) begin
			overflow <= 1'b0;
		end else if (drop) begin
			overflow <= 1'b1;
		end else if (overflow_clear) begin
			overflow <= 1'b0;
		end
	end

	// ****************************************
	// Transmit data FIFO
	// ****************************************
	txw_fifo #(
		.WIDTH (TXW_DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.reset     (reset),
		.in_s      (push_if),
		.out_data  (tx_data),
		.out_valid (tx_valid),
		.out_ready (tx_ready)
	);
endmodule
`default_nettype wire

/* File: tb/txw_props.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************
// Port checks
// ****************
module txw_props import txw_pkg::*; (
	// Clock and reset
	input wire logic                  clock,
	input wire logic                  reset,
	// Host pins
	input wire logic                  chip_select_n,
	input wire logic                  write_strobe_n,
	input wire logic                  fifo_sel,
	input wire logic [TXW_ADDR_MSB:1] addr,
	input wire logic                  bus_16bit,
	// Outputs and status
	input wire logic [TXW_DATA_W-1:0] tx_data,
	input wire logic                  tx_valid,
	input wire logic                  tx_ready,
	input wire logic                  reg_wr_pulse,
	input wire logic [TXW_DATA_W-1:0] reg_wr_data,
	input wire logic                  overflow,
	input wire logic                  overflow_clear
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_reset_quiet: assert property (disable iff (1'b0)
		reset |=> !tx_valid && !overflow && !reg_wr_pulse)
		else $error("outputs active after reset");
	a_reg_write: assert property (
		$rose(chip_select_n) && $past(!write_strobe_n) && !fifo_sel
		&& addr[7:5] != TXW_TX_ALIAS |-> ##[1:5] reg_wr_pulse)
		else $error("ordinary write gave no pulse");
	a_direct_no_reg: assert property (
		fifo_sel [*8] |-> !reg_wr_pulse)
		else $error("direct write reached register path");
	a_pulse_one: assert property (
		reg_wr_pulse |=> !reg_wr_pulse)
		else $error("register pulse too long");
	a_no_select: assert property (
		chip_select_n [*8] |-> !reg_wr_pulse)
		else $error("pulse without chip select");
	a_no_strobe: assert property (
		write_strobe_n [*8] |-> !reg_wr_pulse)
		else $error("pulse without write strobe");
	a_head_hold: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("head word lost while stalled");
	a_ovf_sticky: assert property (
		overflow && !overflow_clear |=> overflow)
		else $error("overflow dropped by itself");
	a_upper_zero: assert property (
		bus_16bit && $past(bus_16bit, 8) && reg_wr_pulse
		|-> reg_wr_data[31:16] == 16'h0)
		else $error("upper half kept on narrow bus");

	c_drain: cover property (tx_valid && tx_ready);
	c_reg: cover property (reg_wr_pulse);
	c_ovf: cover property (overflow);
endmodule
bind txw_write_port txw_props chk_u (
	.clock          (clock),
	.reset          (reset),
	.chip_select_n  (chip_select_n),
	.write_strobe_n (write_strobe_n),
	.fifo_sel       (fifo_sel),
	.addr           (addr),
	.bus_16bit      (bus_16bit),
	.tx_data        (tx_data),
	.tx_valid       (tx_valid),
	.tx_ready       (tx_ready),
	.reg_wr_pulse   (reg_wr_pulse),
	.reg_wr_data    (reg_wr_data),
	.overflow       (overflow),
	.overflow_clear (overflow_clear)
);
`default_nettype wire

/* File: tb/txw_sink.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************
// Drain-side model
// ****************
module txw_sink import txw_pkg::*; (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  reset,
	// Word stream
	input  wire logic [TXW_DATA_W-1:0] tx_data,
	input  wire logic                  tx_valid,
	output logic                       tx_ready,
	// Bench control
	input  wire logic                  stall
);
	logic [TXW_DATA_W-1:0] words [64];
	int                    cnt;
	// Slow or prompt answer
	assign tx_ready = !stall;
	always_ff @(posedge clock) begin
		if (reset) begin
			cnt <= 0;
		end else if (tx_valid && tx_ready) begin
			words[cnt[5:0]] <= tx_data;
			cnt             <= cnt + 1;
		end
	end
endmodule
`default_nettype wire

/* File: tb/tb_txw_write_port.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************
// Write port bench
// ****************
module tb_txw_write_port import txw_pkg::*;;
	logic                  clock = 1'b0, reset = 1'b1, fifo_sel = 1'b0;
	logic                  chip_select_n = 1'b1, write_strobe_n = 1'b1;
	logic                  bus_16bit = 1'b0, overflow_clear = 1'b0;
	logic                  stall = 1'b0, tx_valid, tx_ready;
	logic                  reg_wr_pulse, overflow;
	logic [TXW_ADDR_MSB:1] addr = 7'h00, reg_wr_addr;
	logic [TXW_DATA_W-1:0] data = 32'h0, tx_data, reg_wr_data;
	int                    error_cnt = 0, checks = 0, cyc = 0, base;
	int                    pulses = 0;

	txw_write_port dut_u (
		.clock          (clock),
		.reset          (reset),
		.chip_select_n  (chip_select_n),
		.write_strobe_n (write_strobe_n),
		.fifo_sel       (fifo_sel),
		.addr           (addr),
		.data           (data),
		.bus_16bit      (bus_16bit),
		.tx_data        (tx_data),
		.tx_valid       (tx_valid),
		.tx_ready       (tx_ready),
		.reg_wr_pulse   (reg_wr_pulse),
		.reg_wr_addr    (reg_wr_addr),
		.reg_wr_data    (reg_wr_data),
		.overflow       (overflow),
		.overflow_clear (overflow_clear)
	);
	txw_sink snk_u (
		.clock    (clock),
		.reset    (reset),
		.tx_data  (tx_data),
		.tx_valid (tx_valid),
		.tx_ready (tx_ready),
		.stall    (stall)
	);

	// Free-running clock
	initial begin
		forever #5 clock = ~clock;
	end
	// Hang ceiling
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			complete_run();
		end
	end
	// Register pulses seen, counted where settled
	always @(negedge clock) begin
		if (reg_wr_pulse === 1'b1) begin
			pulses <= pulses + 1;
		end
	end

	task automatic complete_run();
		$display("mismatches %0d, checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk_word(logic [31:0] got, logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(logic got, logic exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: flag %b", $time, got);
		end
	endtask
	// 40 ns low, 70 ns per cycle
	task automatic host_write(logic by_wr, logic sel, logic [7:1] a,
		logic [31:0] d);
		@(negedge clock);
		fifo_sel = sel;
		addr = a;
		data = d;
		chip_select_n = 1'b0;
		write_strobe_n = 1'b0;
		repeat (4) @(negedge clock);
		if (by_wr) write_strobe_n = 1'b1;
		else chip_select_n = 1'b1;
		repeat (2) @(negedge clock);
	endtask
	task automatic settle(int n);
		for (int i = 0; i < 60 && snk_u.cnt != n; i++) @(negedge clock);
		repeat (6) @(negedge clock);
	endtask

	task automatic t_direct32();
		int p;
		p = pulses;
		base = snk_u.cnt;
		for (int i = 0; i < 4; i++)
			host_write(i[0], 1'b1, {~i[2:0], 4'h0}, 32'h1234_5670 + i);
		settle(base + 4);
		chk_word(snk_u.cnt, base + 4);
		for (int i = 0; i < 4; i++)
			chk_word(snk_u.words[base + i], 32'h1234_5670 + i);
		chk_word({25'h0, reg_wr_addr}, 32'h0);
		chk_word(pulses, p);
	endtask
	task automatic t_reg();
		int p;
		p = pulses;
		base = snk_u.cnt;
		host_write(1'b0, 1'b0, 7'h24, 32'h0bad_cafe);
		settle(base);
		chk_word({25'h0, reg_wr_addr}, 32'h24);
		chk_word(reg_wr_data, 32'h0bad_cafe);
		chk_word(snk_u.cnt, base);
		chk_word(pulses, p + 1);
		// Ordinary write to the FIFO alias, select low
		host_write(1'b0, 1'b0, 7'h12, 32'h5a5a_0001);
		settle(base + 1);
		chk_word(snk_u.cnt, base + 1);
		chk_word(snk_u.words[base], 32'h5a5a_0001);
		chk_word({25'h0, reg_wr_addr}, 32'h24);
		chk_word(pulses, p + 1);
	endtask
	task automatic t_half16();
		int p;
		p = pulses;
		bus_16bit = 1'b1;
		base = snk_u.cnt;
		host_write(1'b1, 1'b1, 7'h7e, 32'hdead_1111);
		host_write(1'b0, 1'b1, 7'h01, 32'hbeef_2222);
		host_write(1'b0, 1'b0, 7'h30, 32'hffff_abcd);
		settle(base + 1);
		chk_word(snk_u.words[base], 32'h2222_1111);
		chk_word(snk_u.cnt, base + 1);
		chk_word(reg_wr_data, 32'h0000_abcd);
		chk_word(pulses, p + 1);
		bus_16bit = 1'b0;
	endtask
	task automatic t_fill();
		stall = 1'b1;
		base = snk_u.cnt;
		for (int i = 0; i < 20; i++)
			host_write(1'b0, 1'b1, 7'h00, 32'h00c0_0000 + i);
		repeat (8) @(negedge clock);
		chk_flag(overflow, 1'b1);
		stall = 1'b0;
		settle(base + 18);
		chk_word(snk_u.cnt, base + 18);
		for (int i = 0; i < 18; i++)
			chk_word(snk_u.words[base + i], 32'h00c0_0000 + i);
		chk_flag(tx_valid, 1'b0);
		overflow_clear = 1'b1;
		@(negedge clock);
		overflow_clear = 1'b0;
		@(negedge clock);
		chk_flag(overflow, 1'b0);
	endtask

	// Reset, then each scenario in turn
	initial begin
		repeat (10) @(negedge clock);
		reset = 1'b0;
		repeat (3) @(negedge clock);
		t_direct32();
		t_reg();
		t_half16();
		t_fill();
		complete_run();
	end
endmodule
`default_nettype wire
